// >>> rtl/stp_pkg.sv
// Constants, register map and shared decode for the spanning tree port gate
package stp_pkg;

  // ------------------------------------------------------------
  // Ports and frame descriptor layout
  // ------------------------------------------------------------
  localparam int unsigned NUM_NET    = 4;
  localparam logic [2:0]  HOST_PORT  = 3'h5;
  localparam int unsigned HOST_BIT   = 4;
  localparam int unsigned DESC_W     = 17;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned SRC_LSB    = 0;
  localparam int unsigned DST_LSB    = 3;
  localparam int unsigned TAG_LSB    = 8;
  localparam int unsigned OVR_BIT    = 16;
  localparam int unsigned TAG_LOOKUP = 7;

  // ------------------------------------------------------------
  // Register map: indices, byte address is four times the index
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W       = 10;
  localparam logic [7:0]  GLOBAL_IDX   = 8'h0c;
  localparam logic [7:0]  STATUS_IDX   = 8'h70;
  localparam logic [7:0]  PORT_IDX [4] = '{8'h12, 8'h22, 8'h32, 8'h42};
  localparam int unsigned TX_BIT       = 2;
  localparam int unsigned RX_BIT       = 1;
  localparam int unsigned LRN_BIT      = 0;
  localparam int unsigned TAIL_BIT     = 1;
  localparam logic [7:0]  PORT_RST     = 8'h06;
  localparam logic [7:0]  GLOBAL_RST   = 8'h00;

  // ------------------------------------------------------------
  // Gate sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    STP_IDLE   = 3'h1,
    STP_DECIDE = 3'h2,
    STP_EMIT   = 3'h4
  } stp_fsm_t;

  // One-hot network port bit for a source number, zero for the host
  function automatic logic [3:0] stp_net_onehot(input logic [2:0] src);
    logic [3:0] oh;
    oh = 4'h0;
    for (int i = 0; i < NUM_NET; i++) begin
      if (src == 3'(i + 1)) begin
        oh[i] = 1'b1;
      end
    end
    return oh;
  endfunction

endpackage

// >>> rtl/stp_fifo.sv
// Descriptor FIFO with valid/ready on both sides
module stp_fifo #(
  parameter int unsigned W     = 17,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData,
  output logic [3:0]        level
);
  localparam int unsigned PW = $clog2(DEPTH);

  // Depth must be a power of two so the pointers wrap by themselves
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wrPtr;
    logic [PW-1:0]           rdPtr;
    logic [PW:0]             count;
  } stp_fifo_t;

  stp_fifo_t st;
  stp_fifo_t next_st;
  logic      push;
  logic      pop;

  assign inReady  = (st.count != (PW+1)'(DEPTH));
  assign outValid = (st.count != '0);
  assign outData  = st.mem[st.rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign level    = 4'(st.count);

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wrPtr] = inData;
      next_st.wrPtr         = st.wrPtr + 1'b1;
    end
    if (pop) begin
      next_st.rdPtr = st.rdPtr + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// >>> rtl/stp_apb_regs.sv
// APB register file: per-port tree state control, global control, status
module stp_apb_regs (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [3:0]       txEn,
  output logic [3:0]       rxEn,
  output logic [3:0]       learnDis,
  output logic             tailEn,
  input  wire logic [31:0] statusWord
);
  typedef struct packed {
    logic [3:0][7:0] portCtrl;
    logic [7:0]      globalCtrl;
  } stp_regs_t;

  stp_regs_t  st;
  stp_regs_t  next_st;
  logic [7:0] wordIdx;
  logic [3:0] portHit;
  logic       hitGlobal;
  logic       hitStatus;
  logic       mapped;
  logic       access;

  assign wordIdx   = paddr[9:2];
  assign hitGlobal = (paddr[1:0] == 2'h0) && (wordIdx == stp_pkg::GLOBAL_IDX);
  assign hitStatus = (paddr[1:0] == 2'h0) && (wordIdx == stp_pkg::STATUS_IDX);
  assign mapped    = hitGlobal || hitStatus || (|portHit);
  assign access    = psel && penable;
  // Zero wait states: every access completes in its first access cycle
  assign pready    = 1'b1;
  assign pslverr   = access && !mapped;
  assign tailEn    = st.globalCtrl[stp_pkg::TAIL_BIT];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gPort
      assign portHit[g]  = (paddr[1:0] == 2'h0) && (wordIdx == stp_pkg::PORT_IDX[g]);
      assign txEn[g]     = st.portCtrl[g][stp_pkg::TX_BIT];
      assign rxEn[g]     = st.portCtrl[g][stp_pkg::RX_BIT];
      assign learnDis[g] = st.portCtrl[g][stp_pkg::LRN_BIT];
    end
  endgenerate

  always_comb begin
    next_st = st;
    prdata  = 32'h0;
    for (int i = 0; i < 4; i++) begin
      if (portHit[i]) begin
        prdata = {24'h0, st.portCtrl[i]};
        if (access && pwrite) begin
          next_st.portCtrl[i] = pwdata[7:0];
        end
      end
    end
    if (hitGlobal) begin
      prdata = {24'h0, st.globalCtrl};
      if (access && pwrite) begin
        next_st.globalCtrl = pwdata[7:0];
      end
    end
    // Status is read only; writes there are ignored
    if (hitStatus) begin
      prdata = statusWord;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st.portCtrl   <= {4{stp_pkg::PORT_RST}};
      st.globalCtrl <= stp_pkg::GLOBAL_RST;
    end else begin
      st <= next_st;
    end
  end
endmodule

// >>> rtl/stp_port_gate.sv
// Spanning tree port gate: filters forwarding and learning per network port
//
// Function
// - Port five is the host port; only ports one to four have tree state.
// - Each network port has transmit, receive and learning-disable bits in its register.
// - Transmit and receive off with learning off blocks user frames both ways.
// - Blocking passes only frames to the host and learns nothing.
// - Listening exchanges only host frames both ways, learning stays off.
// - Learning state learns source addresses yet passes only host traffic.
// - All enabled: frames forward and receive normally and addresses are learned.
// - Learning-disable set suppresses learning; cleared, learning happens.
// - Disabled ports still deliver static override matches to the host.
// - Low four bits of the host trailing tag select destination ports.
// - Trailing tag steering acts only while its global enable bit is set.
module stp_port_gate (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        descValid,
  output logic             descReady,
  input  wire logic [2:0]  descSrc,
  input  wire logic [4:0]  descDst,
  input  wire logic [7:0]  descTag,
  input  wire logic        descOverride,
  output logic             fwdValid,
  input  wire logic        fwdReady,
  output logic [4:0]       fwdMask,
  output logic [2:0]       fwdSrc,
  output logic             learnPulse,
  output logic [2:0]       learnPort,
  output logic             dropPulse
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    stp_pkg::stp_fsm_t fsm;
    logic [2:0]        src;
    logic [4:0]        dst;
    logic [7:0]        tag;
    logic              ovr;
    logic              fwdValid;
    logic [4:0]        fwdMask;
    logic [2:0]        fwdSrc;
    logic              direct;
    logic              learnPulse;
    logic [2:0]        learnPort;
    logic              dropPulse;
    logic [15:0]       dropCount;
  } stp_gate_t;

  stp_gate_t                   st;
  stp_gate_t                   next_st;
  logic [3:0]                  txEn;
  logic [3:0]                  rxEn;
  logic [3:0]                  learnDis;
  logic                        tailEn;
  logic [31:0]                 statusWord;
  logic [3:0]                  fifoLevel;
  logic                        qValid;
  logic                        qReady;
  logic [stp_pkg::DESC_W-1:0]  qData;
  logic [stp_pkg::DESC_W-1:0]  inWord;
  logic [3:0]                  netBit;
  logic                        fromNet;
  logic                        fromHost;
  logic                        useTag;
  logic [4:0]                  srcMask;
  logic [4:0]                  mask;

  // ------------------------------------------------------------
  // Register file and descriptor queue
  // ------------------------------------------------------------
  stp_apb_regs uRegs (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .txEn       (txEn),
    .rxEn       (rxEn),
    .learnDis   (learnDis),
    .tailEn     (tailEn),
    .statusWord (statusWord)
  );

  assign inWord = {descOverride, descTag, descDst, descSrc};

  // Back-pressure reaches the lookup stage through descReady
  stp_fifo #(
    .W     (stp_pkg::DESC_W),
    .DEPTH (stp_pkg::FIFO_DEPTH)
  ) uFifo (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .inValid  (descValid),
    .inReady  (descReady),
    .inData   (inWord),
    .outValid (qValid),
    .outReady (qReady),
    .outData  (qData),
    .level    (fifoLevel)
  );

  assign qReady     = (st.fsm == stp_pkg::STP_IDLE);
  assign statusWord = {st.dropCount, 9'h0, st.fsm, fifoLevel};

  assign fwdValid   = st.fwdValid;
  assign fwdMask    = st.fwdMask;
  assign fwdSrc     = st.fwdSrc;
  assign learnPulse = st.learnPulse;
  assign learnPort  = st.learnPort;
  assign dropPulse  = st.dropPulse;

  // ------------------------------------------------------------
  // Gating decision
  // ------------------------------------------------------------
  assign netBit   = stp_pkg::stp_net_onehot(st.src);
  assign fromNet  = |netBit;
  assign fromHost = (st.src == stp_pkg::HOST_PORT);
  assign srcMask  = {fromHost, netBit};
  // Tag bit seven set means ordinary lookup even with tagging on
  assign useTag   = fromHost && tailEn && !st.tag[stp_pkg::TAG_LOOKUP];

  always_comb begin
    if (useTag) begin
      // Direct injection bypasses transmit enables; tag 0 is reserved
      mask = {1'b0, st.tag[3:0]};
    end else if (fromNet && !(|(netBit & rxEn))) begin
      // Same bits for disabled, blocking, listening, learning: host-only
      mask = {st.dst[stp_pkg::HOST_BIT] & st.ovr, 4'h0};
    end else begin
      mask = {st.dst[stp_pkg::HOST_BIT], st.dst[3:0] & txEn} & ~srcMask;
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_st            = st;
    next_st.learnPulse = 1'b0;
    next_st.dropPulse  = 1'b0;
    case (st.fsm)
      stp_pkg::STP_IDLE: begin
        if (qValid) begin
          next_st.src = qData[stp_pkg::SRC_LSB +: 3];
          next_st.dst = qData[stp_pkg::DST_LSB +: 5];
          next_st.tag = qData[stp_pkg::TAG_LSB +: 8];
          next_st.ovr = qData[stp_pkg::OVR_BIT];
          next_st.fsm = stp_pkg::STP_DECIDE;
        end
      end
      stp_pkg::STP_DECIDE: begin
        // Learning follows only the disable bit, never the rx/tx bits
        if (fromNet && !(|(netBit & learnDis))) begin
          next_st.learnPulse = 1'b1;
          next_st.learnPort  = st.src;
        end
        next_st.direct = useTag;
        next_st.fwdSrc = st.src;
        if (mask == 5'h00) begin
          next_st.dropPulse = 1'b1;
          next_st.dropCount = st.dropCount + 16'h0001;
          next_st.fsm       = stp_pkg::STP_IDLE;
        end else begin
          next_st.fwdValid = 1'b1;
          next_st.fwdMask  = mask;
          next_st.fsm      = stp_pkg::STP_EMIT;
        end
      end
      stp_pkg::STP_EMIT: begin
        if (fwdReady) begin
          next_st.fwdValid = 1'b0;
          next_st.fsm      = stp_pkg::STP_IDLE;
        end
      end
      default: begin
        next_st.fwdValid = 1'b0;
        next_st.fsm      = stp_pkg::STP_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st     <= '0;
      st.fsm <= stp_pkg::STP_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  logic        decideNet;
  logic [3:0]  decideBit;
  logic        ovrFlag;
  logic [4:0]  lookupMask;
  logic [15:0] dropTotal;
  assign decideNet  = (st.fsm == stp_pkg::STP_DECIDE) && fromNet;
  assign decideBit  = netBit;
  assign ovrFlag    = st.ovr;
  assign lookupMask = {1'b0, st.dst[3:0] & txEn};
  assign dropTotal  = st.dropCount;

  a_host_never_learns: assert property (
    learnPulse |-> (learnPort != stp_pkg::HOST_PORT)
  ) else $error("learning reported for the host port");

  a_rx_block_gate: assert property (
    decideNet && !(|(decideBit & rxEn)) |=> !fwdValid || (fwdMask[3:0] == 4'h0)
  ) else $error("frame from a receive-disabled port reached a network port");

  a_block_host_only: assert property (
    decideNet && !(|(decideBit & rxEn)) && !ovrFlag |=> !fwdValid && dropPulse
  ) else $error("non-override frame from a blocked port was not dropped");

  a_tx_block_gate: assert property (
    (st.fsm == stp_pkg::STP_DECIDE) && !useTag
      |=> !fwdValid || ((fwdMask[3:0] & ~$past(txEn)) == 4'h0)
  ) else $error("lookup frame sent to a transmit-disabled port");

  a_learn_gate_off: assert property (
    decideNet && (|(decideBit & learnDis)) |=> !learnPulse
  ) else $error("address learned on a learning-disabled port");

  a_learn_gate_on: assert property (
    decideNet && !(|(decideBit & learnDis)) |=> learnPulse && (learnPort == $past(st.src))
  ) else $error("address not learned on a learning-enabled port");

  a_override_to_host: assert property (
    decideNet && st.ovr && st.dst[stp_pkg::HOST_BIT] |=> fwdValid && fwdMask[stp_pkg::HOST_BIT]
  ) else $error("override frame did not reach the host");

  a_forward_normal: assert property (
    decideNet && (|(decideBit & rxEn)) && ((st.dst[3:0] & ~txEn) == 4'h0)
      && ((st.dst[3:0] & decideBit) == 4'h0) && (st.dst != 5'h00)
      |=> fwdValid && (fwdMask == $past(st.dst))
  ) else $error("forwarding port did not pass its frame unchanged");

  a_tail_direct: assert property (
    (st.fsm == stp_pkg::STP_DECIDE) && useTag && (st.tag[3:0] != 4'h0)
      |=> fwdValid && (fwdMask == {1'b0, $past(st.tag[3:0])})
  ) else $error("tail tag did not steer the host frame");

  a_tail_disabled: assert property (
    (st.fsm == stp_pkg::STP_DECIDE) && fromHost && !tailEn |=> !fwdValid || !st.direct
  ) else $error("tail tag used while tagging disabled");

  a_emit_stable: assert property (
    fwdValid && !fwdReady |=> fwdValid && $stable(fwdMask) && $stable(fwdSrc)
  ) else $error("forward request changed before it was taken");

  a_drop_excludes_fwd: assert property (
    dropPulse |-> !fwdValid
  ) else $error("frame both dropped and offered for forwarding");

  a_drop_counter: assert property (
    dropPulse |-> (dropTotal == $past(dropTotal) + 16'h0001)
  ) else $error("drop counter did not follow a dropped frame");

  a_queue_ready: assert property (
    descReady == (fifoLevel != 4'(stp_pkg::FIFO_DEPTH))
  ) else $error("buffer ready flag disagrees with its fill level");

  a_lookup_tx_mask: assert property (
    (st.fsm == stp_pkg::STP_DECIDE) && fromHost && !tailEn && (lookupMask != 5'h00)
      |=> fwdValid && (fwdMask == $past(lookupMask))
  ) else $error("host frame without tagging bypassed the lookup mask");

  a_learn_one_cycle: assert property (
    learnPulse |=> !learnPulse
  ) else $error("learn request lasted more than one cycle");

  a_emit_release: assert property (
    fwdValid && fwdReady |=> !fwdValid
  ) else $error("forward request stayed up after it was taken");

  a_idle_no_emit: assert property (
    (st.fsm == stp_pkg::STP_IDLE) |-> !fwdValid
  ) else $error("forward request raised while the sequencer idles");
endmodule

// >>> verification/stp_host_model.sv
// Host processor model at the fifth port: takes forwarded frames
module stp_host_model (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       slowMode,
  input  wire logic       hold,
  input  wire logic [3:0] portOff,
  input  wire logic       fwdValid,
  input  wire logic [2:0] fwdSrc,
  output logic            fwdReady,
  output int              keptCount
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] pace;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pace      <= 2'h0;
      fwdReady  <= 1'b0;
      keptCount <= 0;
    end else begin
      pace     <= pace + 2'h1;
      // Slow mode takes one frame in four cycles
      fwdReady <= !hold && (!slowMode || pace == 2'h3);
      // Frames from a disabled port are taken but thrown away
      if (fwdValid && fwdReady && !(fwdSrc inside {[3'h1:3'h4]} && portOff[fwdSrc - 3'h1])) begin
        keptCount <= keptCount + 1;
      end
    end
  end
endmodule

// >>> verification/tb_spanning_tree_port_gate.sv
// Self-checking bench for the spanning tree port gate
module tb_spanning_tree_port_gate;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [9:0]  paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, descReady, fwdValid, fwdReady, learnPulse, dropPulse;
  logic        descValid = 1'b0;
  logic [2:0]  descSrc = 3'h1;
  logic [4:0]  descDst = 5'h00;
  logic [7:0]  descTag = 8'h00;
  logic        descOverride = 1'b0;
  logic        slowMode = 1'b0;
  logic        hold = 1'b0;
  logic [4:0]  fwdMask;
  logic [2:0]  fwdSrc, learnPort;
  int          keptCount;
  int          failures = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          dropExp = 0;
  int          keptExp = 0;
  logic [31:0] rnd = 32'h3d23014a;
  logic [7:0]  portReg [4] = '{default: 8'h06};
  logic        tailOn = 1'b0;
  logic [7:0]  expQ [$];
  logic [2:0]  learnQ [$];
  logic [3:0]  portOff;

  assign portOff = {portReg[3][0], portReg[2][0], portReg[1][0], portReg[0][0]};

  always #5 ref_clk = ~ref_clk;

  stp_port_gate i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .descValid(descValid), .descReady(descReady), .descSrc(descSrc),
    .descDst(descDst), .descTag(descTag), .descOverride(descOverride), .fwdValid(fwdValid),
    .fwdReady(fwdReady), .fwdMask(fwdMask), .fwdSrc(fwdSrc), .learnPulse(learnPulse),
    .learnPort(learnPort), .dropPulse(dropPulse));

  stp_host_model i_host (.ref_clk(ref_clk), .sys_rst(sys_rst), .slowMode(slowMode),
    .hold(hold), .portOff(portOff), .fwdValid(fwdValid), .fwdSrc(fwdSrc),
    .fwdReady(fwdReady), .keptCount(keptCount));

  // ------------------------------------------------------------
  // Checking, model and verdict
  // ------------------------------------------------------------
  task automatic complete_run();
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected result: 8'h00 for a drop, else {source, mask}
  function automatic logic [7:0] modelResult(input logic [2:0] s, input logic [4:0] d,
                                             input logic [7:0] t, input logic o);
    logic [3:0] tx;
    logic [4:0] m;
    for (int i = 0; i < 4; i++) tx[i] = portReg[i][2];
    if (s == 3'h5)
      m = (tailOn && !t[7]) ? {1'b0, t[3:0]} : {1'b0, d[3:0] & tx};
    else if (!portReg[s - 3'h1][1])
      m = (d[4] && o) ? 5'h10 : 5'h00;
    else
      m = {d[4], d[3:0] & tx} & ~(5'h01 << (s - 3'h1));
    return (m == 5'h00) ? 8'h00 : {s, m};
  endfunction

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      complete_run();
    end
    if (!sys_rst) begin
      if (fwdValid === 1'b1 && fwdReady === 1'b1)
        check({fwdSrc, fwdMask}, expQ.size() ? expQ.pop_front() : 8'hff);
      if (dropPulse === 1'b1)
        check(8'h00, expQ.size() ? expQ.pop_front() : 8'hff);
      if (learnPulse === 1'b1)
        check(learnPort, learnQ.size() ? learnQ.pop_front() : 3'h0);
    end
  end

  // ------------------------------------------------------------
  // Bus and stream drivers
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the slave
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic setPort(input int p, input logic [7:0] v);
    logic [31:0] r;
    logic        e;
    rnd = lfsr(rnd);
    // Upper bits carry noise: only the low byte belongs to the register
    apb(1'b1, {stp_pkg::PORT_IDX[p], 2'b00}, {rnd[31:8], v}, r, e);
    portReg[p] = v;
  endtask

  task automatic send(input logic [2:0] s, input logic [4:0] d, input logic [7:0] t,
                      input logic o);
    logic [7:0] res;
    @(posedge ref_clk);
    descValid    <= 1'b1;
    descSrc      <= s;
    descDst      <= d;
    descTag      <= t;
    descOverride <= o;
    // The offer stands until the buffer takes it
    do begin
      @(posedge ref_clk);
    end while (descReady !== 1'b1);
    res = modelResult(s, d, t, o);
    expQ.push_back(res);
    // Host keeps all but what comes from a port with learning disabled
    if (res == 8'h00) dropExp++;
    else if (!(s inside {[3'h1:3'h4]} && portReg[s - 3'h1][0])) keptExp++;
    if (s != 3'h5 && !portReg[s - 3'h1][0]) learnQ.push_back(s);
    descValid <= 1'b0;
  endtask

  task automatic randFrame();
    logic [2:0] s;
    logic [3:0] allow;
    rnd = lfsr(rnd);
    s = 3'(rnd[2:0] % 5 + 1);
    for (int i = 0; i < 4; i++) allow[i] = !portReg[i][0];
    // Host sends only toward learning or forwarding ports
    if (s == 3'h5)
      send(s, {rnd[8], rnd[7:4] & allow}, {rnd[16], 3'h0, rnd[12:9] & allow}, rnd[17]);
    else
      send(s, rnd[8:4], rnd[16:9], rnd[17]);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while ((expQ.size() || learnQ.size()) && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    check(expQ.size() + learnQ.size(), 0);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic        e;
    int          n;
    logic [7:0]  v;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int p = 0; p < 4; p++) begin
      apb(1'b0, {stp_pkg::PORT_IDX[p], 2'b00}, 32'h0, r, e);
      check(r, 32'h06);
      check(e, 1'b0);
    end
    apb(1'b0, 10'h3fc, 32'h0, r, e);
    check(r, 32'h0);
    check(e, 1'b1);
    apb(1'b1, 10'h049, 32'h1, r, e);
    check(e, 1'b1);
    apb(1'b0, {stp_pkg::PORT_IDX[0], 2'b00}, 32'h0, r, e);
    check(r, 32'h06);
    for (int p = 0; p < 4; p++) begin
      rnd = lfsr(rnd);
      apb(1'b1, {stp_pkg::PORT_IDX[p], 2'b00}, rnd, r, e);
      apb(1'b0, {stp_pkg::PORT_IDX[p], 2'b00}, 32'h0, r, e);
      check(r, {24'h0, rnd[7:0]});
    end
    // Each tree state in turn, then a mix across ports
    for (int k = 0; k < 4; k++) begin
      tailOn = k[0];
      apb(1'b1, 10'h030, {30'h0, tailOn, 1'b0}, r, e);
      apb(1'b0, {stp_pkg::GLOBAL_IDX, 2'b00}, 32'h0, r, e);
      check(r, {30'h0, tailOn, 1'b0});
      for (int p = 0; p < 4; p++) begin
        rnd = lfsr(rnd);
        n = (k == 3) ? int'(rnd[3:0] % 3) : k;
        v = (n == 0) ? 8'h01 : (n == 1) ? 8'h00 : 8'h06;
        setPort(p, v);
      end
      slowMode <= k[1];
      repeat (30) randFrame();
      drain();
    end
    // Fill the buffer with the host stalled: eight held plus one on the output
    for (int p = 0; p < 4; p++) setPort(p, 8'h06);
    hold <= 1'b1;
    n = 0;
    // Offer only while the buffer shows room, so no offer is ever withdrawn
    while (n < 12) begin
      @(negedge ref_clk);
      if (descReady !== 1'b1) break;
      send(3'h1, 5'h02, 8'h00, 1'b0);
      n++;
    end
    check(n, 9);
    hold <= 1'b0;
    drain();
    apb(1'b0, {stp_pkg::STATUS_IDX, 2'b00}, 32'h0, r, e);
    check(r, {dropExp[15:0], 16'h0010});
    check(keptCount, keptExp);
    complete_run();
  end
endmodule
